// ---- logic/ldm_defs.svh ----
// Constants for the legacy DMA mode and clear port block
`ifndef LDM_DEFS_SVH
`define LDM_DEFS_SVH
`define LDM_OFF_MODE      8'h0B
`define LDM_OFF_FF_CLEAR  8'h0C
`define LDM_OFF_MCLEAR    8'h0D
`define LDM_LEG_MODE      16'h000B
`define LDM_LEG_FF_CLEAR  16'h000C
`define LDM_LEG_MCLEAR    16'h000D
`define LDM_MODE_RST      8'h00
`define LDM_CHAN_LSB      0
`define LDM_CHAN_MSB      1
`define LDM_OFF_MASK      16'hFFF0
`define LDM_LEG_BASE      16'h0000
`define LDM_OFS_LSB       0
`define LDM_OFS_MSB       3
`define LDM_RDATA_IDLE    8'h00
`endif

// ---- logic/ldm_pkg.sv ----
// Types for the legacy DMA mode and clear port block
package ldm_pkg;
  typedef enum logic [2:0] {
    LDM_SRC_NONE   = 3'b001,
    LDM_SRC_SLAVE  = 3'b010,
    LDM_SRC_LEGACY = 3'b100
  } ldm_src_t;
endpackage : ldm_pkg

// ---- logic/ldm_decode.sv ----
// Address decoder for slave, audio and legacy windows
`timescale 1ns/1ns
`default_nettype none
`include "ldm_defs.svh"
module ldm_decode
  import ldm_pkg::*;
(
  input  wire logic [15:0] io_addr,
  input  wire logic [15:0] dma_slave_io_base,
  input  wire logic [15:0] audio_io_base,
  output logic             hit_slave,
  output logic             hit_audio,
  output logic             hit_legacy,
  output logic [7:0]       offset
);
  // Windows are 16 bytes, aligned on their base
  always_comb begin
    hit_slave  = (io_addr & `LDM_OFF_MASK) == (dma_slave_io_base & `LDM_OFF_MASK);
    hit_audio  = (io_addr & `LDM_OFF_MASK) == (audio_io_base & `LDM_OFF_MASK);
    hit_legacy = (io_addr & `LDM_OFF_MASK) == `LDM_LEG_BASE;
    offset     = {4'h0, io_addr[`LDM_OFS_MSB:`LDM_OFS_LSB]};
  end
endmodule : ldm_decode
`default_nettype wire

// ---- logic/ldm_mode_clear.sv ----
// Legacy DMA channel mode register, flip-flop clear and master clear ports
`timescale 1ns/1ns
`default_nettype none
`include "ldm_defs.svh"
module ldm_mode_clear
  import ldm_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire logic        io_wr,
  input  wire logic        io_rd,
  input  wire logic [15:0] io_addr,
  input  wire logic [7:0]  io_wdata,
  input  wire logic [15:0] dma_slave_io_base,
  input  wire logic [15:0] audio_io_base,
  input  wire logic        legacy_snoop_enable,
  input  wire logic [1:0]  snoop_channel,
  input  wire logic        byte_ptr_toggle,
  output logic [7:0]       io_rdata,
  output logic             io_claim,
  output logic [7:0]       channel_mode,
  output logic             byte_ptr_flag,
  output logic             channel_reset
);
  logic       hit_slave;
  logic       hit_audio;
  logic       hit_legacy;
  logic [7:0] offset;
  logic       wr_slave;
  logic       wr_snoop;
  logic       mode_wr;
  logic       ffc_wr;
  logic       mclr_wr;
  logic [7:0] mode_q;
  logic       ptr_q;
  logic       reset_q;
  logic [7:0] rdata_q;
  ldm_src_t   src;
  logic       any_wr;
  logic       snoop_chan_ok;

  // ---------------------------------------------------------------
  // Overview
  // ---------------------------------------------------------------
  // Two system types share this logic. With a distributed master,
  // legacy cycles are forwarded into the slave window, so only the
  // slave decode matters. Without one, software writes the legacy
  // addresses directly and snooping picks them up. Both paths can be
  // active at once; the slave window wins when they overlap.
  //
  // Reads of the mode register come back only through the audio
  // window. The slave and legacy windows return zero for that
  // offset, so a master merging channel bytes never sees our mode.
  //
  // The byte pointer flag here serves the system without a
  // distributed master; with one, the master keeps its own copy and
  // this flag is simply never consulted.

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  // True when the window offset selects the given port
  function automatic logic ldm_port_sel(input logic [7:0] off,
                                        input logic [7:0] port);
    ldm_port_sel = (off == port);
  endfunction : ldm_port_sel

  // True when the channel field of a written byte names our channel
  function automatic logic ldm_chan_match(input logic [7:0] data,
                                          input logic [1:0] chan);
    ldm_chan_match = (data[`LDM_CHAN_MSB:`LDM_CHAN_LSB] == chan);
  endfunction : ldm_chan_match

  // ---------------------------------------------------------------
  // Decode
  // ---------------------------------------------------------------
  ldm_decode u_dec (
    .io_addr           (io_addr),
    .dma_slave_io_base (dma_slave_io_base),
    .audio_io_base     (audio_io_base),
    .hit_slave         (hit_slave),
    .hit_audio         (hit_audio),
    .hit_legacy        (hit_legacy),
    .offset            (offset)
  );

  // Slave writes from the DMA master or software; snoop from legacy space
  // Slave tested first so an overlap never counts a write twice
  always_comb begin
    if (hit_slave) begin
      src = LDM_SRC_SLAVE;
    end else if (hit_legacy && legacy_snoop_enable) begin
      src = LDM_SRC_LEGACY;
    end else begin
      src = LDM_SRC_NONE;
    end
  end

  // Split the write strobe by source; every code is reachable
  always_comb begin
    wr_slave = 1'b0;
    wr_snoop = 1'b0;
    unique case (src)
      LDM_SRC_SLAVE: begin
        wr_slave = io_wr;
      end
      LDM_SRC_LEGACY: begin
        wr_snoop = io_wr;
      end
      LDM_SRC_NONE: begin
        wr_slave = 1'b0;
      end
    endcase
  end

  // Any accepted write, whichever window it came through
  assign any_wr        = wr_slave || wr_snoop;
  // Channel field check gates only snooped mode writes
  assign snoop_chan_ok = ldm_chan_match(io_wdata, snoop_channel);

  // Slave writes always land; snooped ones need a channel match
  assign mode_wr = (wr_slave && ldm_port_sel(offset, `LDM_OFF_MODE))
                || (wr_snoop && ldm_port_sel(offset, `LDM_OFF_MODE)
                    && snoop_chan_ok);
  // Data ignored, only the write event matters
  assign ffc_wr  = any_wr && ldm_port_sel(offset, `LDM_OFF_FF_CLEAR);
  assign mclr_wr = any_wr && ldm_port_sel(offset, `LDM_OFF_MCLEAR);

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  // Mode register; master clear returns it to reset value
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      mode_q <= `LDM_MODE_RST;
    end else if (mclr_wr) begin
      mode_q <= `LDM_MODE_RST;
    end else if (mode_wr) begin
      mode_q <= io_wdata;
    end
  end

  // Byte pointer flag; clears win over the transfer engine toggle
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ptr_q <= 1'b0;
    end else if (ffc_wr || mclr_wr) begin
      ptr_q <= 1'b0;
    end else if (byte_ptr_toggle) begin
      ptr_q <= ~ptr_q;
    end
  end

  // One-cycle reset pulse to the rest of the channel
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      reset_q <= 1'b0;
    end else begin
      reset_q <= mclr_wr;
    end
  end

  // ---------------------------------------------------------------
  // Read path
  // ---------------------------------------------------------------
  // Mode only visible through the audio window, never slave or legacy
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rdata_q <= `LDM_RDATA_IDLE;
    end else if (io_rd && hit_audio && !hit_slave
                 && ldm_port_sel(offset, `LDM_OFF_MODE)) begin
      rdata_q <= mode_q;
    end else begin
      rdata_q <= `LDM_RDATA_IDLE;              // Idle zero keeps merged reads clean
    end
  end

  // Legacy reads unclaimed unless snooping is on
  assign io_claim = io_rd && (hit_slave || hit_audio
                    || (hit_legacy && legacy_snoop_enable));

  // ---------------------------------------------------------------
  // Integration notes
  // ---------------------------------------------------------------
  // io_claim is combinational so the bus interface can answer in the
  // address phase; io_rdata follows one clock later from a register.
  // Audio and slave bases must differ, otherwise mode reads through
  // the audio window are hidden behind the slave decode.
  // Writes through the audio window have no effect on this block.
  // channel_reset is a single-cycle pulse; downstream address and
  // count registers must act on it in that cycle or lose it.
  // A master clear in the same cycle as a mode write or a toggle
  // wins, so a half-finished sequence cannot survive the reset.
  // A clear and a toggle in one cycle leave the pointer flag low,
  // which matches what software expects right after its clear.

  // Outputs straight from their registers
  assign io_rdata      = rdata_q;
  assign channel_mode  = mode_q;
  assign byte_ptr_flag = ptr_q;
  assign channel_reset = reset_q;
endmodule : ldm_mode_clear
`default_nettype wire

// ---- verification/ldm_host.sv ----
// Host bridge model issuing I/O cycles
`timescale 1ns/1ns
`default_nettype none
module ldm_host (
  input  wire logic        ref_clk,
  input  wire logic        io_claim,
  input  wire logic [7:0]  io_rdata,
  output logic             io_wr,
  output logic             io_rd,
  output logic [15:0]      io_addr,
  output logic [7:0]       io_wdata
);
  initial {io_wr, io_rd, io_addr, io_wdata} = '0;
  // Forwarded write; a released bus shows the inverse
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge ref_clk) {io_wr, io_addr, io_wdata} <= {1'b1, a, d};
    @(posedge ref_clk) {io_wr, io_addr, io_wdata} <= {1'b0, ~a, ~d};
  endtask : wr
  // Claim seen in the request cycle, data in the cycle after
  task automatic rd(input logic [15:0] a, output logic [7:0] d, output logic c);
    @(posedge ref_clk) {io_rd, io_addr} <= {1'b1, a};
    #1 c = io_claim;
    @(posedge ref_clk) {io_rd, io_addr} <= {1'b0, ~a};
    #1 d = io_rdata;
  endtask : rd
endmodule : ldm_host
`default_nettype wire

// ---- verification/ldm_mode_clear_chk.sv ----
// Checker for the mode and clear ports
`timescale 1ns/1ns
`default_nettype none
module ldm_mode_clear_chk (
  input wire logic        ref_clk,
  input wire logic        rst,
  input wire logic        io_wr,
  input wire logic        io_rd,
  input wire logic        io_claim,
  input wire logic        legacy_snoop_enable,
  input wire logic        byte_ptr_flag,
  input wire logic        channel_reset,
  input wire logic [15:0] io_addr,
  input wire logic [15:0] dma_slave_io_base,
  input wire logic [15:0] audio_io_base,
  input wire logic [7:0]  io_wdata,
  input wire logic [7:0]  io_rdata,
  input wire logic [7:0]  channel_mode,
  input wire logic [1:0]  snoop_channel
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  // Window hits; a legacy hit needs snooping on
  wire s = io_addr[15:4] == dma_slave_io_base[15:4];
  wire l = io_addr[15:4] == 12'h000 && legacy_snoop_enable;
  wire h = io_wr && (s || l);
  wire [3:0] o = io_addr[3:0];
  // Mode write accepted: slave path, or snoop with matching channel
  wire m = s || io_wdata[1:0] == snoop_channel;
  wire mc = h && o == 4'hD;
  chk_mode_wr: assert property (h && o == 4'hB && m
    |=> channel_mode == $past(io_wdata)) else $error("mode");
  chk_mode_hold: assert property (io_wr && o == 4'hB && !(h && m)
    |=> $stable(channel_mode)) else $error("hold");
  chk_ff_clr: assert property (h && o == 4'hC |=> !byte_ptr_flag)
    else $error("flag");
  chk_mclr: assert property (mc |=> channel_reset && !byte_ptr_flag
    && channel_mode == 8'h00 ##1 channel_reset == $past(mc)) else $error("mclr");
  chk_mclr_off: assert property (io_wr && o == 4'hD && !h |=> !channel_reset)
    else $error("off");
  chk_claim: assert property (io_rd && io_addr[15:4] == 12'h000
    |-> io_claim == legacy_snoop_enable) else $error("claim");
  chk_aud_rd: assert property (io_rd && io_addr == {audio_io_base[15:4], 4'hB}
    |-> io_claim ##1 io_rdata == $past(channel_mode)) else $error("aud");
  chk_slv_rd: assert property (io_rd && s && o == 4'hB |=> io_rdata == 8'h00)
    else $error("slv");
  cover property (io_rd && io_claim);
  cover property (channel_reset);
  cover property ($fell(byte_ptr_flag));
  cover property (h && l && o == 4'hB);
endmodule : ldm_mode_clear_chk
bind ldm_mode_clear ldm_mode_clear_chk i_ldm_mode_clear_chk (
  .ref_clk             (ref_clk),
  .rst                 (rst),
  .io_wr               (io_wr),
  .io_rd               (io_rd),
  .io_claim            (io_claim),
  .legacy_snoop_enable (legacy_snoop_enable),
  .byte_ptr_flag       (byte_ptr_flag),
  .channel_reset       (channel_reset),
  .io_addr             (io_addr),
  .dma_slave_io_base   (dma_slave_io_base),
  .audio_io_base       (audio_io_base),
  .io_wdata            (io_wdata),
  .io_rdata            (io_rdata),
  .channel_mode        (channel_mode),
  .snoop_channel       (snoop_channel)
);
`default_nettype wire

// ---- verification/ldm_mode_clear_tb.sv ----
// Bench for the mode and clear ports
`timescale 1ns/1ns
`default_nettype none
module ldm_mode_clear_tb;
  logic ref_clk = 0, rst = 1, legacy_snoop_enable = 0, byte_ptr_toggle = 0;
  logic io_wr, io_rd, io_claim, byte_ptr_flag, channel_reset;
  logic [15:0] io_addr, dma_slave_io_base = 16'h0040, audio_io_base = 16'h0080;
  logic [7:0] io_wdata, io_rdata, channel_mode, d;
  logic [1:0] snoop_channel = 2'h1;
  logic c;
  int failures = 0, tests_run = 0, cyc = 0;
  always #2 ref_clk = ~ref_clk;
  ldm_host i_ldm_host (
    .ref_clk  (ref_clk),
    .io_claim (io_claim),
    .io_rdata (io_rdata),
    .io_wr    (io_wr),
    .io_rd    (io_rd),
    .io_addr  (io_addr),
    .io_wdata (io_wdata)
  );
  ldm_mode_clear i_ldm_mode_clear (
    .ref_clk             (ref_clk),
    .rst                 (rst),
    .io_wr               (io_wr),
    .io_rd               (io_rd),
    .io_addr             (io_addr),
    .io_wdata            (io_wdata),
    .dma_slave_io_base   (dma_slave_io_base),
    .audio_io_base       (audio_io_base),
    .legacy_snoop_enable (legacy_snoop_enable),
    .snoop_channel       (snoop_channel),
    .byte_ptr_toggle     (byte_ptr_toggle),
    .io_rdata            (io_rdata),
    .io_claim            (io_claim),
    .channel_mode        (channel_mode),
    .byte_ptr_flag       (byte_ptr_flag),
    .channel_reset       (channel_reset)
  );
  task automatic ck(input string n, input logic [7:0] e, g);
    tests_run++;
    if (g !== e) begin
      failures++;
      $display("[ERR] %s exp %h got %h", n, e, g);
    end
  endtask : ck
  task automatic tog;
    @(posedge ref_clk) byte_ptr_toggle <= 1;
    @(posedge ref_clk) byte_ptr_toggle <= 0;
  endtask : tog
  task automatic test_done;
    $display("checks %0d fails %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : test_done
  // Hang guard, far above the expected run
  always @(posedge ref_clk) if (++cyc == 500) begin
    failures++;
    test_done;
  end
  initial begin
    repeat (8) @(posedge ref_clk);
    rst <= 0;
    #1 ck("rst mode", 8'h00, channel_mode);
    i_ldm_host.wr(16'h004B, 8'hA5);
    i_ldm_host.rd(16'h008B, d, c);
    ck("aud rd", 8'hA5, d);
    ck("aud claim", 8'h01, {7'h0, c});
    i_ldm_host.rd(16'h004B, d, c);
    ck("slv rd", 8'h00, d);
    @(posedge ref_clk) legacy_snoop_enable <= 1;
    i_ldm_host.wr(16'h000B, 8'h39);
    i_ldm_host.wr(16'h000B, 8'h3A);
    #1 ck("snoop", 8'h39, channel_mode);
    i_ldm_host.rd(16'h000B, d, c);
    ck("leg rd", 8'h00, d);
    ck("leg claim", 8'h01, {7'h0, c});
    $display("mode test done");
    tog;
    i_ldm_host.wr(16'h004C, 8'h5A);
    #1 ck("ff", 8'h00, {7'h0, byte_ptr_flag});
    tog;
    #1 ck("toggle", 8'h01, {7'h0, byte_ptr_flag});
    i_ldm_host.wr(16'h000C, 8'hFF);
    #1 ck("snoop ff", 8'h00, {7'h0, byte_ptr_flag});
    tog;
    i_ldm_host.wr(16'h000D, 8'h00);
    #1 ck("mclr", 8'h00, channel_mode);
    ck("pulse", 8'h01, {6'h0, byte_ptr_flag, channel_reset});
    @(posedge ref_clk) legacy_snoop_enable <= 0;
    i_ldm_host.wr(16'h004B, 8'h77);
    i_ldm_host.wr(16'h004D, 8'hC3);
    #1 ck("slv pulse", 8'h01, {7'h0, channel_reset});
    i_ldm_host.wr(16'h000B, 8'h39);
    #1 ck("slv mclr", 8'h00, channel_mode);
    tog;
    i_ldm_host.wr(16'h000D, 8'h00);
    #1 ck("leg off", 8'h02, {6'h0, byte_ptr_flag, channel_reset});
    i_ldm_host.rd(16'h000B, d, c);
    ck("leg noclaim", 8'h00, {7'h0, c});
    $display("clear test done");
    test_done;
  end
endmodule : ldm_mode_clear_tb
`default_nettype wire
